// ===== core/gdc_ctrl.sv
// Function
// - The filament is on and the sensor active for as long as the sensor input is grounded.
// - Releasing the sensor input turns the filament off when that input alone held it on.
// - A grounding edge on the degas input is taken as a degas start request.
// - A started degas runs its configured two to ten minutes whatever the degas input does.
// - A new degas start from the degas input needs that input released and grounded again.
// - A grounded emission input or a set emission command selects 4 mA, otherwise 100 uA is selected.
// - The degas status transistor conducts exactly while degas is active.
// - The sensor status transistor conducts exactly while the filament is on.
// - Filament, emission and degas are also commanded by serial registers and panel keys.
// - After power-up the filament stays off until an activation request arrives.
`timescale 1ns/100ps
module gdc_ctrl #(
    parameter int CYC_PER_SEC = gdc_pkg::CYC_PER_SEC,
    parameter int DEB_CYC     = gdc_pkg::DEB_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        sensor_on_n,
    input  wire logic        degas_req_n,
    input  wire logic        emis_sel_n,
    input  wire logic        panel_fil_tgl,
    input  wire logic        panel_emis_tgl,
    input  wire logic        panel_degas_tgl,
    output logic             ion_gauge_filament,
    output logic             emis_high,
    output logic             degas_active,
    input  wire logic        degas_stat_i,
    output logic             degas_stat_o,
    output logic             degas_stat_oe,
    input  wire logic        sensor_stat_i,
    output logic             sensor_stat_o,
    output logic             sensor_stat_oe
);

    gdc_pkg::gdc_st_t st_r;
    gdc_pkg::gdc_st_t st_nxt;

    logic [gdc_pkg::NPIN-1:0] pins_n;
    logic [gdc_pkg::NPIN-1:0] gnd;
    logic [gdc_pkg::NPIN-1:0] gnd_rise;
    logic                     sw_go;
    logic                     sw_stop;
    logic                     dg_go;
    logic                     dg_stop;
    logic                     sec_tick;
    gdc_pkg::gdc_sel_t        wsel;

    if (CYC_PER_SEC < 2 || CYC_PER_SEC > 2 ** gdc_pkg::PRE_W) begin : g_bad_sec
        $error("gdc_ctrl: CYC_PER_SEC out of range");
    end

    function automatic gdc_pkg::gdc_sel_t reg_sel(input logic [3:0] addr);
        unique case (addr)
            gdc_pkg::OFS_CTRL:  reg_sel = gdc_pkg::SEL_CTRL;
            gdc_pkg::OFS_STAT:  reg_sel = gdc_pkg::SEL_STAT;
            gdc_pkg::OFS_DTIME: reg_sel = gdc_pkg::SEL_DTIME;
            default:            reg_sel = gdc_pkg::SEL_NONE;
        endcase
    endfunction

    function automatic logic [3:0] clamp_min(input logic [3:0] v);
        if (v < gdc_pkg::DG_MIN_LO) begin
            clamp_min = gdc_pkg::DG_MIN_LO;
        end else if (v > gdc_pkg::DG_MIN_HI) begin
            clamp_min = gdc_pkg::DG_MIN_HI;
        end else begin
            clamp_min = v;
        end
    endfunction

    assign pins_n = {sensor_stat_i, degas_stat_i, emis_sel_n, degas_req_n, sensor_on_n};

    for (genvar i = 0; i < gdc_pkg::NPIN; i++) begin : g_pin
        gdc_deb #(
            .DEB_CYC(DEB_CYC)
        ) u_deb (
            .aclk         (aclk),
            .aresetn      (aresetn),
            .pin_n        (pins_n[i]),
            .grounded     (gnd[i]),
            .grounded_rise(gnd_rise[i])
        );
    end

    assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
    assign s_axi_wready  = !st_r.w_got && !st_r.bvalid;
    assign s_axi_arready = !st_r.rvalid;
    assign wsel          = reg_sel(st_r.aw_addr);
    assign sec_tick      = st_r.pre == gdc_pkg::PRE_W'(CYC_PER_SEC - 1);

    always_comb begin
        st_nxt  = st_r;
        sw_go   = 1'b0;
        sw_stop = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            st_nxt.aw_got  = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wstrb = s_axi_wstrb;
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        // Address and data may arrive in either order
        if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = (wsel == gdc_pkg::SEL_NONE) ? gdc_pkg::RESP_SLVERR
                                                        : gdc_pkg::RESP_OKAY;
            if (st_r.wstrb[0]) begin
                unique case (wsel)
                    gdc_pkg::SEL_CTRL: begin
                        st_nxt.fil_cmd  = st_r.wdata[gdc_pkg::CTRL_FIL];
                        st_nxt.emis_cmd = st_r.wdata[gdc_pkg::CTRL_EMIS];
                        sw_go           = st_r.wdata[gdc_pkg::CTRL_DG_GO];
                        sw_stop         = st_r.wdata[gdc_pkg::CTRL_DG_STOP];
                    end
                    // Out-of-range minutes clamp rather than fault
                    gdc_pkg::SEL_DTIME: st_nxt.minutes = clamp_min(st_r.wdata[3:0]);
                    gdc_pkg::SEL_STAT,
                    gdc_pkg::SEL_NONE: ;
                endcase
            end
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = '0;
            st_nxt.rresp  = gdc_pkg::RESP_OKAY;
            unique case (reg_sel(s_axi_araddr))
                gdc_pkg::SEL_CTRL: begin
                    st_nxt.rdata[gdc_pkg::CTRL_FIL]  = st_r.fil_cmd;
                    st_nxt.rdata[gdc_pkg::CTRL_EMIS] = st_r.emis_cmd;
                end
                gdc_pkg::SEL_STAT: begin
                    st_nxt.rdata[gdc_pkg::STAT_FIL]  = st_r.fil_on;
                    st_nxt.rdata[gdc_pkg::STAT_EMIS] = st_r.emis_hi;
                    st_nxt.rdata[gdc_pkg::STAT_DG]   = st_r.dg == gdc_pkg::DG_RUN;
                    st_nxt.rdata[gdc_pkg::STAT_PIN_LSB +: gdc_pkg::NPIN] = gnd;
                    st_nxt.rdata[gdc_pkg::STAT_SECS_LSB +: gdc_pkg::SEC_W] = st_r.secs;
                end
                gdc_pkg::SEL_DTIME: st_nxt.rdata[3:0] = st_r.minutes;
                gdc_pkg::SEL_NONE:  st_nxt.rresp = gdc_pkg::RESP_SLVERR;
            endcase
        end else if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (panel_fil_tgl) begin
            st_nxt.fil_cmd = ~st_nxt.fil_cmd;
        end
        if (panel_emis_tgl) begin
            st_nxt.emis_cmd = ~st_nxt.emis_cmd;
        end
        st_nxt.fil_on  = gnd[gdc_pkg::PIN_SENS] | st_nxt.fil_cmd;
        st_nxt.emis_hi = gnd[gdc_pkg::PIN_EMIS] | st_nxt.emis_cmd;
        // held pin gives no second edge
        dg_go   = gnd_rise[gdc_pkg::PIN_DG] | sw_go |
                  (panel_degas_tgl && st_r.dg == gdc_pkg::DG_IDLE);
        dg_stop = sw_stop | (panel_degas_tgl && st_r.dg == gdc_pkg::DG_RUN);
        unique case (st_r.dg)
            gdc_pkg::DG_IDLE: begin
                if (dg_go) begin
                    st_nxt.dg   = gdc_pkg::DG_RUN;
                    st_nxt.secs = gdc_pkg::SEC_W'(st_r.minutes * gdc_pkg::SEC_PER_MIN);
                    st_nxt.pre  = '0;
                end
            end
            gdc_pkg::DG_RUN: begin
                // runs to term unless stopped by command
                if (dg_stop) begin
                    st_nxt.dg   = gdc_pkg::DG_IDLE;
                    st_nxt.secs = '0;
                end else if (sec_tick) begin
                    st_nxt.pre = '0;
                    if (st_r.secs <= gdc_pkg::SEC_W'(1)) begin
                        st_nxt.dg   = gdc_pkg::DG_IDLE;
                        st_nxt.secs = '0;
                    end else begin
                        st_nxt.secs = st_r.secs - 1'b1;
                    end
                end else begin
                    st_nxt.pre = st_r.pre + 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r         <= '0;
            st_r.dg      <= gdc_pkg::DG_IDLE;
            st_r.minutes <= gdc_pkg::DG_MIN_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_bvalid       = st_r.bvalid;
    assign s_axi_bresp        = st_r.bresp;
    assign s_axi_rvalid       = st_r.rvalid;
    assign s_axi_rdata        = st_r.rdata;
    assign s_axi_rresp        = st_r.rresp;
    assign ion_gauge_filament = st_r.fil_on;
    assign emis_high          = st_r.emis_hi;
    assign degas_active       = st_r.dg == gdc_pkg::DG_RUN;
    // Open collector: only ever pulls low
    assign degas_stat_o       = 1'b0;
    assign sensor_stat_o      = 1'b0;
    assign degas_stat_oe      = st_r.dg == gdc_pkg::DG_RUN;
    assign sensor_stat_oe     = st_r.fil_on;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_fil_on_pin : assert property (gnd[gdc_pkg::PIN_SENS] |=> ion_gauge_filament)
        else $error("filament not on while sensor input grounded");
    a_fil_off_rel : assert property (
        !gnd[gdc_pkg::PIN_SENS] && !st_nxt.fil_cmd |=> !ion_gauge_filament)
        else $error("filament stayed on after sensor input release");
    a_dg_edge_go : assert property (
        gnd_rise[gdc_pkg::PIN_DG] && !degas_active |=> degas_active)
        else $error("degas edge did not start degas");
    a_dg_runs_on : assert property (
        degas_active && st_r.secs > 10'h001 && !dg_stop |=> degas_active)
        else $error("degas ended before its time");
    a_dg_term : assert property (
        degas_active && sec_tick && st_r.secs == 10'h001 |=> !degas_active)
        else $error("degas ran past its time");
    a_dtime_range : assert property (
        st_r.minutes >= gdc_pkg::DG_MIN_LO && st_r.minutes <= gdc_pkg::DG_MIN_HI)
        else $error("degas minute setting outside two to ten");
    a_dg_no_retrig : assert property (!degas_active && !dg_go |=> !degas_active)
        else $error("degas started without a request");
    a_emis_sel : assert property (gnd[gdc_pkg::PIN_EMIS] |=> emis_high)
        else $error("4 mA not selected while emission input grounded");
    a_emis_low : assert property (
        !gnd[gdc_pkg::PIN_EMIS] && !st_nxt.emis_cmd |=> !emis_high)
        else $error("4 mA held with no request for it");
    a_dg_stat : assert property (degas_stat_oe == degas_active && !degas_stat_o)
        else $error("degas status output disagrees with degas state");
    a_sens_stat : assert property (sensor_stat_oe == ion_gauge_filament)
        else $error("sensor status output disagrees with filament");
    a_sw_fil : assert property (
        st_r.aw_got && st_r.w_got && !st_r.bvalid && st_r.wstrb[0]
        && wsel == gdc_pkg::SEL_CTRL && st_r.wdata[0] && !panel_fil_tgl
        |=> ion_gauge_filament)
        else $error("register command did not turn filament on");
    a_cmd_fil : assert property (st_nxt.fil_cmd |=> ion_gauge_filament)
        else $error("filament command did not turn filament on");
    a_cmd_emis : assert property (st_nxt.emis_cmd |=> emis_high)
        else $error("emission command did not select 4 mA");

    // Write answers one edge after address and data are both held, read one edge after its handshake
    a_w_answer : assert property (
        st_r.aw_got && st_r.w_got && !st_r.bvalid |=> s_axi_bvalid)
        else $error("write response missing");
    a_b_done : assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not withdrawn");
    a_r_answer : assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data missing");
    a_r_done : assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data not withdrawn");

    a_reset_off : assert property (disable iff (1'b0)
        !aresetn |=> !ion_gauge_filament && !degas_active)
        else $error("filament or degas on after reset");
    a_dg_load : assert property (
        !degas_active && dg_go
        |=> st_r.secs == gdc_pkg::SEC_W'($past(st_r.minutes) * gdc_pkg::SEC_PER_MIN))
        else $error("degas timer not loaded from minute setting");
    a_dg_count : assert property (
        degas_active && sec_tick && st_r.secs > 10'h001 && !dg_stop
        |=> st_r.secs == $past(st_r.secs) - 10'h001)
        else $error("degas seconds did not count down");

endmodule // gdc_ctrl

// ===== core/gdc_pkg.sv
package gdc_pkg;

    // Clock and time bases
    localparam int CLK_PERIOD_NS = 25;
    localparam int SEC_NS        = 1_000_000_000;
    localparam int CYC_PER_SEC   = SEC_NS / CLK_PERIOD_NS;
    localparam int SEC_PER_MIN   = 60;
    // Debounce settle time, a least time so it rounds up
    localparam int DEB_TIME_US   = 1000;
    localparam int DEB_CYC       = (DEB_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Counter widths
    localparam int PRE_W = 26;
    localparam int SEC_W = 10;
    localparam int DEB_W = 16;

    // Degas length in minutes
    localparam logic [3:0] DG_MIN_LO  = 4'h2;
    localparam logic [3:0] DG_MIN_HI  = 4'hA;
    localparam logic [3:0] DG_MIN_RST = 4'hA;

    // Register byte offsets
    localparam logic [3:0] OFS_CTRL  = 4'h0;
    localparam logic [3:0] OFS_STAT  = 4'h4;
    localparam logic [3:0] OFS_DTIME = 4'h8;

    // Control bits
    localparam int CTRL_FIL     = 0;
    localparam int CTRL_EMIS    = 1;
    localparam int CTRL_DG_GO   = 2;
    localparam int CTRL_DG_STOP = 3;

    // Status bits
    localparam int STAT_FIL      = 0;
    localparam int STAT_EMIS     = 1;
    localparam int STAT_DG       = 2;
    localparam int STAT_PIN_LSB  = 4;
    localparam int STAT_SECS_LSB = 16;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Ground-closure pins, index into the synchroniser bank
    localparam int NPIN      = 5;
    localparam int PIN_SENS  = 0;
    localparam int PIN_DG    = 1;
    localparam int PIN_EMIS  = 2;
    localparam int PIN_DGST  = 3;
    localparam int PIN_SNST  = 4;

    typedef enum logic {
        DG_IDLE,
        DG_RUN
    } gdc_dg_t;

    typedef enum logic [1:0] {
        SEL_CTRL,
        SEL_STAT,
        SEL_DTIME,
        SEL_NONE
    } gdc_sel_t;

    typedef struct packed {
        logic             s1;
        logic             s2;
        logic             s3;
        logic             lvl;
        logic             rise;
        logic [DEB_W-1:0] cnt;
    } gdc_deb_t;

    typedef struct packed {
        gdc_dg_t          dg;
        logic [PRE_W-1:0] pre;
        logic [SEC_W-1:0] secs;
        logic             fil_cmd;
        logic             emis_cmd;
        logic             fil_on;
        logic             emis_hi;
        logic [3:0]       minutes;
        logic             aw_got;
        logic [3:0]       aw_addr;
        logic             w_got;
        logic [31:0]      wdata;
        logic [3:0]       wstrb;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
    } gdc_st_t;

endpackage

// ===== core/gdc_deb.sv
`timescale 1ns/100ps
module gdc_deb #(
    parameter int DEB_CYC = gdc_pkg::DEB_CYC
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic pin_n,
    output logic      grounded,
    output logic      grounded_rise
);

    gdc_pkg::gdc_deb_t st_r;
    gdc_pkg::gdc_deb_t st_nxt;

    if (DEB_CYC < 1 || DEB_CYC >= 2 ** gdc_pkg::DEB_W) begin : g_bad_deb
        $error("gdc_deb: DEB_CYC out of range");
    end

    always_comb begin
        st_nxt      = st_r;
        st_nxt.s1   = pin_n;
        st_nxt.s2   = st_r.s1;
        st_nxt.s3   = st_r.s2;
        st_nxt.rise = 1'b0;
        if (st_r.s2 == st_r.s3 && st_r.s3 == st_r.lvl) begin
            if (st_r.cnt == gdc_pkg::DEB_W'(DEB_CYC - 1)) begin
                st_nxt.cnt  = '0;
                st_nxt.lvl  = ~st_r.s3;
                st_nxt.rise = ~st_r.s3;
            end else begin
                st_nxt.cnt = st_r.cnt + 1'b1;
            end
        end else begin
            st_nxt.cnt = '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b0, rise: 1'b0, cnt: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Stored lvl is the grounded state, active high
    assign grounded      = st_r.lvl;
    assign grounded_rise = st_r.rise;

    a_deb_settle : assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(st_r.lvl) |-> $past(st_r.s3) == ~st_r.lvl && $past(st_r.s2) == ~st_r.lvl)
        else $error("pin level changed before synchroniser agreed");
    a_deb_rise : assert property (@(posedge aclk) disable iff (!aresetn)
        grounded_rise |-> grounded)
        else $error("grounding edge flagged without a grounded level");

endmodule // gdc_deb

// ===== sim/gdc_ext_ctl.sv
`timescale 1ns/100ps
module gdc_ext_ctl (
    input  wire logic aclk,
    input  wire logic degas_stat_o,
    input  wire logic degas_stat_oe,
    input  wire logic sensor_stat_o,
    input  wire logic sensor_stat_oe,
    output logic      sensor_on_n,
    output logic      degas_req_n,
    output logic      emis_sel_n,
    output logic      degas_line,
    output logic      sensor_line
);
    assign degas_line  = degas_stat_oe ? degas_stat_o : 1'b1;
    assign sensor_line = sensor_stat_oe ? sensor_stat_o : 1'b1;

    initial begin
        sensor_on_n = 1'b1;
        degas_req_n = 1'b1;
        emis_sel_n  = 1'b1;
    end

    // Pin 0 sensor, 1 degas, 2 emission
    task automatic drive(input int pin, input logic lvl);
        case (pin)
            0: sensor_on_n <= lvl;
            1: degas_req_n <= lvl;
            default: emis_sel_n <= lvl;
        endcase
    endtask

    task automatic degas_pulse(input int n);
        degas_req_n <= 1'b0;
        repeat (n) @(posedge aclk);
        degas_req_n <= 1'b1;
    endtask
endmodule // gdc_ext_ctl

// ===== sim/gdc_ctrl_tb_top.sv
`timescale 1ns/100ps
module gdc_ctrl_tb_top;
    // Short counts keep the two-minute degas near 1200 cycles
    localparam int CPS    = 10;
    localparam int DG_CYC = 2 * 60 * CPS;
    logic        aclk, aresetn;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [2:0]  pnl;
    logic        sensor_on_n, degas_req_n, emis_sel_n, fil, emis, dg;
    logic        dg_o, dg_oe, sn_o, sn_oe, dg_line, sn_line;
    int          err_count = 0;
    int          check_count = 0;
    int          cyc = 0;

    gdc_ctrl #(.CYC_PER_SEC(CPS), .DEB_CYC(2)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sensor_on_n(sensor_on_n),
        .degas_req_n(degas_req_n), .emis_sel_n(emis_sel_n), .panel_fil_tgl(pnl[0]),
        .panel_emis_tgl(pnl[1]), .panel_degas_tgl(pnl[2]), .ion_gauge_filament(fil),
        .emis_high(emis), .degas_active(dg), .degas_stat_i(dg_line),
        .degas_stat_o(dg_o), .degas_stat_oe(dg_oe), .sensor_stat_i(sn_line),
        .sensor_stat_o(sn_o), .sensor_stat_oe(sn_oe)
    );

    gdc_ext_ctl u_ext (
        .aclk(aclk), .degas_stat_o(dg_o), .degas_stat_oe(dg_oe), .sensor_stat_o(sn_o),
        .sensor_stat_oe(sn_oe), .sensor_on_n(sensor_on_n), .degas_req_n(degas_req_n),
        .emis_sel_n(emis_sel_n), .degas_line(dg_line), .sensor_line(sn_line)
    );

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    task automatic end_of_test();
        if (err_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic sig(input int w);
        case (w)
            0: return fil;
            1: return emis;
            default: return dg;
        endcase
    endfunction

    // Bounded poll; the caller judges the outcome
    task automatic wait_sig(input int w, input logic v, input int lim);
        int n;
        n = 0;
        while (sig(w) !== v && n < lim) begin
            @(posedge aclk);
            n++;
        end
    endtask

    // Ready lines stay high, so only valid and payload move
    task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [1:0] r);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
    endtask

    task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
    endtask

    task automatic panel(input logic [2:0] m);
        pnl <= m;
        @(posedge aclk);
        pnl <= 3'h0;
    endtask

    task automatic t_reset();
        logic [31:0] d;
        logic [1:0]  r;
        chk({fil, emis, dg, dg_line, sn_line}, 32'h3);
        axr(gdc_pkg::OFS_DTIME, d, r);
        chk(d[3:0], 4'hA);
        chk(r, gdc_pkg::RESP_OKAY);
    endtask

    task automatic t_pins();
        u_ext.drive(0, 1'b0);
        @(posedge aclk);
        u_ext.drive(0, 1'b1);
        repeat (12) @(posedge aclk);
        chk(fil, 1'b0);
        u_ext.drive(0, 1'b0);
        wait_sig(0, 1'b1, 20);
        chk({fil, sn_line}, 32'h2);
        u_ext.drive(2, 1'b0);
        wait_sig(1, 1'b1, 20);
        chk({fil, emis}, 32'h3);
        u_ext.drive(0, 1'b1);
        u_ext.drive(2, 1'b1);
        wait_sig(0, 1'b0, 20);
        wait_sig(1, 1'b0, 20);
        chk({fil, emis, sn_line}, 32'h1);
    endtask

    task automatic t_degas();
        logic [31:0] d;
        logic [1:0]  r;
        axw(gdc_pkg::OFS_DTIME, 32'h1, 4'hF, r);
        axr(gdc_pkg::OFS_DTIME, d, r);
        chk(d[3:0], 4'h2);
        u_ext.degas_pulse(8);
        wait_sig(2, 1'b1, 20);
        chk({dg, dg_line}, 32'h2);
        // Pin already released: the cycle must keep running
        repeat (DG_CYC - 100) @(posedge aclk);
        chk(dg, 1'b1);
        wait_sig(2, 1'b0, 200);
        chk({dg, dg_line}, 32'h1);
    endtask

    task automatic t_rearm();
        logic [1:0] r;
        u_ext.drive(1, 1'b0);
        wait_sig(2, 1'b1, 20);
        chk(dg, 1'b1);
        axw(gdc_pkg::OFS_CTRL, 32'h8, 4'hF, r);
        wait_sig(2, 1'b0, 5);
        repeat (20) @(posedge aclk);
        chk(dg, 1'b0);
        u_ext.drive(1, 1'b1);
        repeat (10) @(posedge aclk);
        u_ext.degas_pulse(8);
        wait_sig(2, 1'b1, 20);
        chk(dg, 1'b1);
        panel(3'h4);
        wait_sig(2, 1'b0, 5);
        chk(dg, 1'b0);
    endtask

    task automatic t_regs();
        logic [31:0] d;
        logic [1:0]  r;
        axw(gdc_pkg::OFS_CTRL, 32'h1, 4'h0, r);
        repeat (3) @(posedge aclk);
        chk(fil, 1'b0);
        axw(gdc_pkg::OFS_CTRL, 32'h1, 4'hF, r);
        wait_sig(0, 1'b1, 5);
        chk({fil, sn_line, r}, 32'h8);
        panel(3'h3);
        wait_sig(1, 1'b1, 5);
        chk({fil, emis}, 32'h1);
        // Keep the 4 mA command bit set so STATUS shows it
        axw(gdc_pkg::OFS_CTRL, 32'h6, 4'hF, r);
        wait_sig(2, 1'b1, 5);
        chk(dg, 1'b1);
        axw(gdc_pkg::OFS_CTRL, 32'hA, 4'hF, r);
        wait_sig(2, 1'b0, 5);
        axr(gdc_pkg::OFS_STAT, d, r);
        chk(d[2:0], 3'h2);
        axw(4'hC, 32'h0, 4'hF, r);
        chk(r, gdc_pkg::RESP_SLVERR);
        axr(4'hC, d, r);
        chk(d, 32'h0);
        chk(r, gdc_pkg::RESP_SLVERR);
    endtask

    initial begin
        aresetn = 1'b0;
        {awaddr, araddr, wstrb, wdata} = '0;
        {awvalid, wvalid, arvalid, pnl} = '0;
        bready  = 1'b1;
        rready  = 1'b1;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_pins();
        t_degas();
        t_rearm();
        t_regs();
        end_of_test();
    end

    // Whole run is near 1350 cycles; a hang is cut well past that
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 6000) begin
            err_count++;
            end_of_test();
        end
    end
endmodule // gdc_ctrl_tb_top
